// [core/usb_cfg_pkg.sv]
/*
  constants for the usb configuration register zero block: offset, field
  positions, reset values and encodings.
  assumes a single 50 MHz clock domain and an apb register bus.
*/
package usb_cfg_pkg;
  localparam logic [11:0] cfg0_offset = 12'h080;
  localparam int lpm_bit = 30;
  localparam int susp_bit = 29;
  localparam int speed_lsb = 13;
  localparam int speed_msb = 15;
  localparam int tx_rst_bit = 10;
  localparam int rx_rst_bit = 9;
  localparam int empty_reply_bit = 6;
  localparam int burst_bit = 5;
  localparam int swap_bit = 4;
  localparam int wake_bit = 2;
  localparam int pwr_bit = 1;
  localparam int nostall_bit = 0;
  localparam logic [31:0] writable_mask = 32'h6000_E067;
  localparam logic [2:0] speed_high = 3'h0;
  localparam logic [2:0] speed_full = 3'h1;
  localparam logic susp_default = 1'b1;
  localparam logic swap_default = 1'b0;
  localparam logic lpm_default = 1'b1;
  localparam logic wake_default = 1'b1;
  localparam logic pwr_default = 1'b1;
  localparam logic flag_zero = 1'b0;
endpackage

// [core/usb_config_zero.sv]
/*
  usb configuration register zero as an apb slave, with the control outputs
  it drives into the usb device core.
  assumes image flags (eeprom/otp) are stable levels from the loader on mclk;
  usb_reset and lite_soft_reset are one-cycle pulses on mclk.
*/
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module usb_config_zero (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_reset,
  input wire logic lite_soft_reset,
  input wire logic reset_protect,
  input wire logic eeprom_present,
  input wire logic otp_programmed,
  input wire logic [31:0] eeprom_flags,
  input wire logic [31:0] otp_flags,
  input wire logic suspend_request,
  output logic suspend_out_n,
  input wire logic in_token_empty,
  output logic in_reply_nak,
  output logic in_reply_zlp,
  input wire logic [7:0] burst_limit,
  input wire logic [7:0] burst_request,
  output logic [7:0] burst_size,
  input wire logic sync_loss,
  output logic bulk_out_stall,
  output logic link_power_mgmt_capable,
  output logic remote_wake_capable,
  output logic self_powered_select,
  output logic [2:0] connect_speed_select,
  output logic bulk_in_transmitter_rst,
  output logic bulk_out_receiver_rst,
  input wire logic phy_dp_out,
  input wire logic phy_dm_out,
  output logic usb_pad_p,
  output logic usb_pad_m
);
  logic lpm_r, susp_r, swap_r, wake_r, pwr_r, empty_r, burst_r, nostall_r;
  logic [2:0] speed_r;
  logic tx_rst_r, rx_rst_r;
  logic [31:0] prdata_r;

  // image value: eeprom wins, then otp, else the fixed default
  wire load = usb_reset | lite_soft_reset;
  wire [31:0] img = eeprom_present ? eeprom_flags : otp_flags;
  wire img_ok = eeprom_present | otp_programmed;
  wire susp_img = img_ok ? img[usb_cfg_pkg::susp_bit] : usb_cfg_pkg::susp_default;
  wire swap_img = img_ok ? img[usb_cfg_pkg::swap_bit] : usb_cfg_pkg::swap_default;
  wire lpm_img = img_ok ? img[usb_cfg_pkg::lpm_bit] : usb_cfg_pkg::lpm_default;
  wire wake_img = img_ok ? img[usb_cfg_pkg::wake_bit] : usb_cfg_pkg::wake_default;
  // power select never consults otp
  wire pwr_img = eeprom_present ? eeprom_flags[usb_cfg_pkg::pwr_bit]
                                : usb_cfg_pkg::pwr_default;
  // protected fields reload on srst, and on a usb or lite reset only when protection is off
  wire prot_load = srst | (load & ~reset_protect);

  // apb decode: zero-wait slave, unmapped reads zero with error
  wire hit = paddr == usb_cfg_pkg::cfg0_offset;
  wire access = psel & penable;
  wire wr = access & pwrite & hit;
  wire [31:0] wd = pwdata & usb_cfg_pkg::writable_mask;
  wire [31:0] rd_word = {1'b0, lpm_r, susp_r, 13'h0000, speed_r, 2'h0,
                         2'h0, 2'h0, empty_r, burst_r, swap_r, 1'b0,
                         wake_r, pwr_r, nostall_r};
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata = prdata_r;

  // read data latched in setup so it stands through the access cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= (psel & ~penable & ~pwrite & hit) ? rd_word : 32'h0000_0000;
    end
  end

  // protected fields
  always_ff @(posedge mclk) begin
    if (prot_load) begin
      lpm_r <= lpm_img;
      susp_r <= susp_img;
      wake_r <= wake_img;
      pwr_r <= pwr_img;
      speed_r <= usb_cfg_pkg::speed_high;
    end else if (wr) begin
      lpm_r <= wd[usb_cfg_pkg::lpm_bit];
      susp_r <= wd[usb_cfg_pkg::susp_bit];
      wake_r <= wd[usb_cfg_pkg::wake_bit];
      pwr_r <= wd[usb_cfg_pkg::pwr_bit];
      speed_r <= wd[usb_cfg_pkg::speed_msb:usb_cfg_pkg::speed_lsb];
    end
  end

  // unprotected fields; swap is read-only and follows the image
  always_ff @(posedge mclk) begin
    if (srst | load) begin
      empty_r <= usb_cfg_pkg::flag_zero;
      burst_r <= usb_cfg_pkg::flag_zero;
      nostall_r <= usb_cfg_pkg::flag_zero;
      swap_r <= swap_img;
    end else if (wr) begin
      empty_r <= wd[usb_cfg_pkg::empty_reply_bit];
      burst_r <= wd[usb_cfg_pkg::burst_bit];
      nostall_r <= wd[usb_cfg_pkg::nostall_bit];
    end
  end

  // self-clearing resets: one-cycle pulse per write of one, never read back
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_rst_r <= 1'b0;
      rx_rst_r <= 1'b0;
    end else begin
      tx_rst_r <= wr & pwdata[usb_cfg_pkg::tx_rst_bit];
      rx_rst_r <= wr & pwdata[usb_cfg_pkg::rx_rst_bit];
    end
  end
  assign bulk_in_transmitter_rst = tx_rst_r;
  assign bulk_out_receiver_rst = rx_rst_r;

  // control outputs into the device core
  assign link_power_mgmt_capable = lpm_r;
  assign suspend_out_n = ~(suspend_request & susp_r);
  assign connect_speed_select = speed_r;
  assign in_reply_nak = in_token_empty & empty_r;
  assign in_reply_zlp = in_token_empty & ~empty_r;
  // with the limit on, cap the request at burst_limit; with it off, pass the request through unchanged
  assign burst_size = (burst_r && burst_request > burst_limit) ? burst_limit
                                                                : burst_request;
  assign bulk_out_stall = sync_loss & ~nostall_r;
  assign remote_wake_capable = wake_r;
  assign self_powered_select = pwr_r;
  // pad routing, a combinational mux after the phy drivers
  assign usb_pad_p = swap_r ? phy_dm_out : phy_dp_out;
  assign usb_pad_m = swap_r ? phy_dp_out : phy_dm_out;

  // lpm capability follows the last write unless a reload wins the cycle
  a_lpm_write: assert property (@(posedge mclk) disable iff (srst)
    wr && !prot_load |=> link_power_mgmt_capable == $past(wd[usb_cfg_pkg::lpm_bit]))
    else $error("lpm write lost");

  // without a write or reload the capability must not drift
  a_lpm_hold: assert property (@(posedge mclk) disable iff (srst)
    !wr && !load |=> $stable(link_power_mgmt_capable))
    else $error("lpm drifted");

  // a cleared permission keeps the suspend pin quiet whatever the core asks
  a_susp_block: assert property (@(posedge mclk) disable iff (srst)
    !susp_r |-> suspend_out_n)
    else $error("suspend leaked");

  // with permission the core's request reaches the pin
  a_susp_pass: assert property (@(posedge mclk) disable iff (srst)
    susp_r |-> suspend_out_n == !suspend_request)
    else $error("suspend not passed");

  // suspend permission is writable
  a_susp_write: assert property (@(posedge mclk) disable iff (srst)
    wr && !prot_load |=> susp_r == $past(wd[usb_cfg_pkg::susp_bit]))
    else $error("suspend write lost");

  // connect speed takes the written code
  a_speed_write: assert property (@(posedge mclk) disable iff (srst)
    wr && !prot_load |=> connect_speed_select ==
      $past(wd[usb_cfg_pkg::speed_msb:usb_cfg_pkg::speed_lsb]))
    else $error("speed write lost");

  // an unprotected reload returns to high speed
  a_speed_reload: assert property (@(posedge mclk) disable iff (srst)
    load && !reset_protect |=> connect_speed_select == usb_cfg_pkg::speed_high)
    else $error("speed reload wrong");

  // the transmitter reset is one cycle wide unless another write repeats it
  a_tx_pulse: assert property (@(posedge mclk) disable iff (srst)
    tx_rst_r |=> !tx_rst_r || $past(wr))
    else $error("tx reset pulse stuck");

  // a written one starts the transmitter reset on the next cycle
  a_tx_start: assert property (@(posedge mclk) disable iff (srst)
    wr && pwdata[usb_cfg_pkg::tx_rst_bit] |=> bulk_in_transmitter_rst)
    else $error("tx reset not pulsed");

  // no write, no transmitter reset
  a_tx_quiet: assert property (@(posedge mclk) disable iff (srst)
    !wr |=> !bulk_in_transmitter_rst)
    else $error("tx reset spurious");

  // a written one starts the receiver reset on the next cycle
  a_rx_pulse: assert property (@(posedge mclk) disable iff (srst)
    $past(wr & pwdata[usb_cfg_pkg::rx_rst_bit]) |-> rx_rst_r)
    else $error("rx reset not pulsed");

  // no write, no receiver reset
  a_rx_quiet: assert property (@(posedge mclk) disable iff (srst)
    !wr |=> !bulk_out_receiver_rst)
    else $error("rx reset spurious");

  // the self-clearing bits never show on the bus
  a_rst_unread: assert property (@(posedge mclk) disable iff (srst)
    !prdata[usb_cfg_pkg::tx_rst_bit] && !prdata[usb_cfg_pkg::rx_rst_bit])
    else $error("reset bit read back");

  // exactly one reply kind on an empty in token, picked by the field
  a_reply_sel: assert property (@(posedge mclk) disable iff (srst)
    in_token_empty |-> (in_reply_nak == empty_r) && (in_reply_zlp != empty_r))
    else $error("empty reply wrong");

  // no reply strobes without an empty in token
  a_reply_idle: assert property (@(posedge mclk) disable iff (srst)
    !in_token_empty |-> !in_reply_nak && !in_reply_zlp)
    else $error("reply without token");

  // with the limit on, the burst is the smaller of request and limit
  a_burst_cap: assert property (@(posedge mclk) disable iff (srst)
    burst_r |-> burst_size <= burst_limit && burst_size <= burst_request &&
      (burst_size == burst_limit || burst_size == burst_request))
    else $error("burst over limit");

  // with the limit off, the request passes unchanged
  a_burst_free: assert property (@(posedge mclk) disable iff (srst)
    !burst_r |-> burst_size == burst_request)
    else $error("burst limited");

  // swapped mapping crosses both lines
  a_pad_swap: assert property (@(posedge mclk) disable iff (srst)
    swap_r |-> usb_pad_p == phy_dm_out && usb_pad_m == phy_dp_out)
    else $error("pad swap wrong");

  // straight mapping keeps both lines
  a_pad_straight: assert property (@(posedge mclk) disable iff (srst)
    !swap_r |-> usb_pad_p == phy_dp_out && usb_pad_m == phy_dm_out)
    else $error("pad straight wrong");

  // the swap bit is read-only: only a reload moves it
  a_swap_ro: assert property (@(posedge mclk) disable iff (srst)
    !load |=> $stable(swap_r))
    else $error("swap bit written");

  // remote wakeup support is writable
  a_wake_write: assert property (@(posedge mclk) disable iff (srst)
    wr && !prot_load |=> remote_wake_capable == $past(wd[usb_cfg_pkg::wake_bit]))
    else $error("wake write lost");

  // power mode is writable
  a_pwr_write: assert property (@(posedge mclk) disable iff (srst)
    wr && !prot_load |=> self_powered_select == $past(wd[usb_cfg_pkg::pwr_bit]))
    else $error("power write lost");

  // sync loss stalls unless the field says carry on
  a_stall_sel: assert property (@(posedge mclk) disable iff (srst)
    sync_loss |-> bulk_out_stall == !nostall_r)
    else $error("stall wrong");

  // never a stall without sync loss
  a_stall_idle: assert property (@(posedge mclk) disable iff (srst)
    !sync_loss |-> !bulk_out_stall)
    else $error("stall without sync loss");

  // suspend permission reloads eeprom first, then otp, else allowed
  a_susp_load: assert property (@(posedge mclk) disable iff (srst)
    load && !reset_protect |=> susp_r == ($past(eeprom_present)
      ? $past(eeprom_flags[usb_cfg_pkg::susp_bit]) : $past(otp_programmed)
      ? $past(otp_flags[usb_cfg_pkg::susp_bit]) : 1'b1))
    else $error("suspend reload wrong");

  // pad swap reloads on every usb or lite reset, protection or not
  a_swap_load: assert property (@(posedge mclk) disable iff (srst)
    load |=> swap_r == ($past(eeprom_present)
      ? $past(eeprom_flags[usb_cfg_pkg::swap_bit]) : $past(otp_programmed)
      ? $past(otp_flags[usb_cfg_pkg::swap_bit]) : 1'b0))
    else $error("swap reload wrong");

  // lpm capability reloads eeprom first, then otp, else enabled
  a_lpm_load: assert property (@(posedge mclk) disable iff (srst)
    load && !reset_protect |=> lpm_r == ($past(eeprom_present)
      ? $past(eeprom_flags[usb_cfg_pkg::lpm_bit]) : $past(otp_programmed)
      ? $past(otp_flags[usb_cfg_pkg::lpm_bit]) : 1'b1))
    else $error("lpm reload wrong");

  // remote wakeup reloads eeprom first, then otp, else supported
  a_wake_load: assert property (@(posedge mclk) disable iff (srst)
    load && !reset_protect |=> wake_r == ($past(eeprom_present)
      ? $past(eeprom_flags[usb_cfg_pkg::wake_bit]) : $past(otp_programmed)
      ? $past(otp_flags[usb_cfg_pkg::wake_bit]) : 1'b1))
    else $error("wake reload wrong");

  // no eeprom means self powered, otp is never asked
  a_pwr_load: assert property (@(posedge mclk) disable iff (srst)
    load && !reset_protect && !eeprom_present |=> pwr_r)
    else $error("pwr default");

  // with an eeprom the power mode comes from its image
  a_pwr_eeprom: assert property (@(posedge mclk) disable iff (srst)
    load && !reset_protect && eeprom_present |=>
      self_powered_select == $past(eeprom_flags[usb_cfg_pkg::pwr_bit]))
    else $error("pwr eeprom wrong");

  // protection keeps every guarded field over a usb or lite reset
  a_prot_hold: assert property (@(posedge mclk) disable iff (srst)
    load && reset_protect && !wr |=> $stable(lpm_r) && $stable(susp_r) &&
      $stable(speed_r) && $stable(wake_r) && $stable(pwr_r))
    else $error("protected field lost");

  // unguarded fields other than swap always clear on a usb or lite reset
  a_unprot_clear: assert property (@(posedge mclk) disable iff (srst)
    load |=> !empty_r && !burst_r && !nostall_r)
    else $error("unprotected field kept");

  // reserved positions of the read word stay zero
  a_resv_zero: assert property (@(posedge mclk) disable iff (srst)
    (rd_word & ~32'h6000_E077) == 32'h0000_0000)
    else $error("reserved set");

  // and nothing reserved ever reaches the bus
  a_resv_read: assert property (@(posedge mclk) disable iff (srst)
    (prdata & ~32'h6000_E077) == 32'h0000_0000)
    else $error("reserved read back");
endmodule
`default_nettype wire

// [sim/usb_host_stub.sv]
/*
  host-side stand-in: suspend, empty-token and sync-loss levels plus line data.
  assumes ctl changes just after a rising mclk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module usb_host_stub (
  input wire logic mclk,
  input wire logic [2:0] ctl,
  output logic suspend_request,
  output logic in_token_empty,
  output logic sync_loss,
  output logic phy_dp_out,
  output logic phy_dm_out
);
  // line data flips every cycle so a stuck pad mux cannot match by luck
  initial phy_dp_out = 1'b0;
  always @(posedge mclk) begin
    phy_dp_out <= ~phy_dp_out;
  end
  assign phy_dm_out = ~phy_dp_out;
  // host-side levels requested by the scenario
  assign {suspend_request, in_token_empty, sync_loss} = ctl;
endmodule
`default_nettype wire

// [sim/usb_config_zero_bench.sv]
/*
  self-checking bench for usb_config_zero over apb.
  waits on pready for apb answers and assumes a host stub on the usb side.
*/
`timescale 1ns/100ps
`default_nettype none
module usb_config_zero_bench;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, usb_reset = 0;
  logic lite_soft_reset = 0, reset_protect = 0, eeprom_present = 0, otp_programmed = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, eeprom_flags = 32'h0000_0000, otp_flags = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic [7:0] burst_limit = 8'h10, burst_request = 8'h40, burst_size;
  logic [2:0] ctl = 3'h0, connect_speed_select;
  logic pready, pslverr, err, suspend_request, suspend_out_n, in_token_empty, in_reply_nak;
  logic in_reply_zlp, sync_loss, bulk_out_stall, link_power_mgmt_capable, remote_wake_capable;
  logic self_powered_select, bulk_in_transmitter_rst, bulk_out_receiver_rst;
  logic phy_dp_out, phy_dm_out, usb_pad_p, usb_pad_m;
  int bad_count = 0, compares = 0;
  usb_config_zero u_dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .usb_reset, .lite_soft_reset, .reset_protect, .eeprom_present,
    .otp_programmed, .eeprom_flags, .otp_flags, .suspend_request, .suspend_out_n,
    .in_token_empty, .in_reply_nak, .in_reply_zlp, .burst_limit, .burst_request, .burst_size,
    .sync_loss, .bulk_out_stall, .link_power_mgmt_capable, .remote_wake_capable,
    .self_powered_select, .connect_speed_select, .bulk_in_transmitter_rst,
    .bulk_out_receiver_rst, .phy_dp_out, .phy_dm_out, .usb_pad_p, .usb_pad_m);
  usb_host_stub u_host (.mclk, .ctl, .suspend_request, .in_token_empty, .sync_loss,
    .phy_dp_out, .phy_dm_out);
  always #10 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, then access held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no assumed wait count: only the watchdog ends a hung access
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_defaults;
    apb(0, 12'h080, 0);
    chk(rd, 32'h0000_0002);
    chk(link_power_mgmt_capable, 0);
    chk(suspend_out_n, 1);
    chk(usb_pad_p, phy_dp_out);
  endtask
  task automatic t_write;
    apb(1, 12'h080, 32'h7FFF_3FFF);
    #1 chk({bulk_in_transmitter_rst, bulk_out_receiver_rst}, 2'b11);
    @(posedge mclk);
    #1 chk({bulk_in_transmitter_rst, bulk_out_receiver_rst}, 2'b00);
    apb(0, 12'h080, 0);
    chk(rd, 32'h6000_2067);
    chk(connect_speed_select, usb_cfg_pkg::speed_full);
    chk({link_power_mgmt_capable, remote_wake_capable, self_powered_select}, 3'h7);
  endtask
  // usb-side outputs with every control bit set, then with all cleared
  task automatic t_outputs(input logic on);
    ctl <= 3'h7;
    @(posedge mclk);
    #1 chk({in_reply_nak, in_reply_zlp}, {on, !on});
    chk(bulk_out_stall, !on);
    chk(suspend_out_n, !on);
    chk(burst_size, on ? 8'h10 : 8'h40);
    chk(usb_pad_m, phy_dm_out);
    @(posedge mclk);
    ctl <= 3'h0;
  endtask
  task automatic t_unmapped;
    apb(1, 12'h084, 32'hFFFF_FFFF);
    chk(err, 1);
    apb(0, 12'h084, 0);
    chk({err, rd}, {1'b1, 32'h0000_0000});
  endtask
  // protected fields survive a usb reset, unprotected ones clear
  task automatic t_protect;
    apb(1, 12'h080, 32'h6000_2067);
    reset_protect <= 1'b1;
    usb_reset <= 1'b1;
    @(posedge mclk);
    usb_reset <= 1'b0;
    apb(0, 12'h080, 0);
    chk(rd, 32'h6000_2006);
    chk(link_power_mgmt_capable, 1);
    chk(self_powered_select, 1);
  endtask
  // nothing programmed gives fixed defaults; a mid-run reset loads the eeprom image
  task automatic t_image;
    reset_protect <= 1'b0;
    otp_programmed <= 1'b0;
    usb_reset <= 1'b1;
    @(posedge mclk);
    usb_reset <= 1'b0;
    apb(0, 12'h080, 0);
    chk(rd, 32'h6000_0006);
    chk(remote_wake_capable, 1);
    eeprom_present <= 1'b1;
    eeprom_flags <= 32'h0000_0010;
    reset_protect <= 1'b1;
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    apb(0, 12'h080, 0);
    chk(rd, 32'h0000_0010);
    chk(self_powered_select, 0);
    chk(usb_pad_p, phy_dm_out);
  endtask
  task automatic conclude;
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    srst <= 0;
    t_defaults();
    t_write();
    t_outputs(1);
    t_unmapped();
    apb(1, 12'h080, 32'h0000_0000);
    t_outputs(0);
    t_protect();
    t_image();
    conclude();
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
